// [pkg/mcier_pkg.sv]
// Shared constants, types and decode helpers of the monitor configuration block
package mcier_pkg;

  localparam int NUM_VOLT  = 5;
  localparam int NUM_TACH  = 4;
  localparam int NUM_DRIVE = 3;
  localparam int ASSOC_W   = 2;

  localparam logic [7:0] ADDR_SPECIAL_FUNC = 8'h7C;
  localparam logic [7:0] ADDR_VOLT_IRQ_EN  = 8'h7E;
  localparam logic [7:0] ADDR_DEV_CFG      = 8'h7F;
  localparam logic [7:0] ADDR_TACH_IRQ_EN  = 8'h80;
  localparam logic [7:0] ADDR_TACH_ASSOC   = 8'h81;

  localparam logic [7:0] RST_SPECIAL_FUNC = 8'h40;
  localparam logic [7:0] RST_VOLT_IRQ_EN  = 8'hEC;
  localparam logic [7:0] RST_DEV_CFG      = 8'h10;
  localparam logic [7:0] RST_TACH_IRQ_EN  = 8'h1E;
  localparam logic [7:0] RST_TACH_ASSOC   = 8'hA4;
  localparam logic [7:0] RDATA_UNMAPPED   = 8'h00;

  // Writable bits; reserved bits are not stored and read as zero, except config bits 5 and 6, which are stored as written
  localparam logic [7:0] VIE_MASK = 8'hED;
  localparam logic [7:0] TIE_MASK = 8'h1F;
  localparam logic [7:0] CFG_MASK = 8'h73;

  localparam int SF_LOW_POWER_BIT   = 0;
  localparam int SF_MONITOR_BIT     = 1;
  localparam int SF_ALERT_EN_BIT    = 2;
  localparam int SF_AVG_LSB         = 5;
  localparam int SF_AVG_MSB         = 7;
  localparam int VIE_GROUP_BIT      = 0;
  localparam int TIE_GROUP_BIT      = 0;
  localparam int TIE_TACH_LSB       = 1;
  localparam int CFG_SPEED3_BIT     = 0;
  localparam int CFG_DRIVE2_BIT     = 1;
  localparam int CFG_TEMP_VALID_BIT = 3;
  localparam int CFG_SPINUP_BIT     = 4;
  localparam int CFG_INIT_BIT       = 7;
  // Enable bit of 2.5V, core supply, 5V, 12V, own supply
  localparam int VOLT_EN_POS [NUM_VOLT] = '{2, 3, 5, 6, 7};

  localparam logic [7:0]  AVG_1   = 8'h01;
  localparam logic [7:0]  AVG_8   = 8'h08;
  localparam logic [7:0]  AVG_16  = 8'h10;
  localparam logic [7:0]  AVG_32  = 8'h20;
  localparam logic [7:0]  AVG_128 = 8'h80;
  localparam logic [7:0]  DUTY_OFF          = 8'h00;
  localparam logic [15:0] TACH_MIN_DISABLED = 16'hFFFF;

  typedef enum logic [1:0]
  {
    MCIER_DRIVE_1    = 2'b00,
    MCIER_DRIVE_2    = 2'b01,
    MCIER_DRIVE_3    = 2'b10,
    MCIER_DRIVE_RSVD = 2'b11
  } mcier_drive_e;

  // Priority decode, top bit first
  function automatic logic [7:0] mcier_avg_count(input logic [2:0] sel, input logic remote);
    if (sel[2])
      return AVG_32;
    else if (sel[1])
      return AVG_16;
    else if (sel[0])
      return remote ? AVG_16 : AVG_1;
    else
      return remote ? AVG_128 : AVG_8;
  endfunction

endpackage

// [pkg/mcier_cfg_if.sv]
// Configuration fields passed from the register bank to its submodules
interface mcier_cfg_if;
  import mcier_pkg::*;
  logic [NUM_VOLT-1:0]         volt_en;
  logic [NUM_TACH-1:0]         tach_en;
  logic [NUM_TACH*ASSOC_W-1:0] assoc;
  logic                        volt_grp_en;
  logic                        tach_grp_en;
  logic                        alert_out_en;
  logic                        speed3_sel;
  logic                        drive2_sel;

  modport src   (output volt_en, tach_en, assoc, volt_grp_en, tach_grp_en, alert_out_en, speed3_sel, drive2_sel);
  modport gate  (input volt_en, tach_en, assoc);
  modport alert (input volt_grp_en, tach_grp_en, alert_out_en, speed3_sel, drive2_sel);
endinterface

// [verilog/mcier_event_gate.sv]
// Gates out-of-limit events into status set pulses
module mcier_event_gate
  import mcier_pkg::*;
(
  input  wire logic                             clk,
  input  wire logic                             sys_rst,
  mcier_cfg_if.gate                             cfg,
  input  wire logic [NUM_VOLT-1:0]              volt_limit_evt,
  input  wire logic [NUM_TACH-1:0]              tach_limit_evt,
  input  wire logic [NUM_DRIVE-1:0][7:0]        drive_duty,
  input  wire logic [NUM_DRIVE-1:0]             fan_disabled,
  input  wire logic [NUM_TACH-1:0][15:0]        tach_min_limit,
  output logic      [NUM_VOLT-1:0]              volt_status_set,
  output logic      [NUM_TACH-1:0]              tach_status_set
);

  // Reserved association code has no drive to follow, so it quiets the tach
  function automatic logic drive_quiet(input logic [ASSOC_W-1:0] code);
    if (code == MCIER_DRIVE_RSVD)
      return 1'b1;
    return (drive_duty[code] == DUTY_OFF) || fan_disabled[code];
  endfunction

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      volt_status_set <= '0;
    else
      volt_status_set <= volt_limit_evt & cfg.volt_en;
  end

  genvar t;
  generate
    for (t = 0; t < NUM_TACH; t++)
    begin : g_tach
      logic suppress;
      assign suppress = drive_quiet(cfg.assoc[t*ASSOC_W +: ASSOC_W])
                        || (tach_min_limit[t] == TACH_MIN_DISABLED);
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          tach_status_set[t] <= 1'b0;
        else
          tach_status_set[t] <= tach_limit_evt[t] && cfg.tach_en[t] && !suppress;
      end
      chk_tach_min_block: assert property (@(posedge clk) disable iff (sys_rst)
        (tach_min_limit[t] == TACH_MIN_DISABLED) |=> !tach_status_set[t])
        else $error("tach status set with minimum limit at full scale");
    end
  endgenerate

  chk_volt_enable_gate: assert property (@(posedge clk) disable iff (sys_rst)
    (volt_limit_evt != '0) |=> (volt_status_set == ($past(volt_limit_evt) & $past(cfg.volt_en))))
    else $error("voltage status set not gated by its enable");

endmodule

// [verilog/mcier_alert_out.sv]
// Alert request combining and shared pin routing
module mcier_alert_out
  import mcier_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  mcier_cfg_if.alert               cfg,
  input  wire logic [NUM_VOLT-1:0] volt_status,
  input  wire logic [NUM_TACH-1:0] tach_status,
  input  wire logic                temp_alert_req,
  input  wire logic                drive2_level,
  input  wire logic                speed3_pin_in,
  output logic                     speed3_pin_out,
  output logic                     speed3_pin_oe,
  output logic                     fan_speed_3_sync,
  output logic                     drive2_pin_out,
  output logic                     drive2_pin_oe,
  output logic                     alert_active
);

  logic sync1_r;
  logic sync2_r;
  logic sync3_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      alert_active <= 1'b0;
    else
      alert_active <= cfg.alert_out_en
                      && ((cfg.volt_grp_en && (|volt_status))
                          || (cfg.tach_grp_en && (|tach_status))
                          || temp_alert_req);
  end

  // Tach pin passes three flops; a level counts once the last two agree
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync1_r          <= 1'b0;
      sync2_r          <= 1'b0;
      sync3_r          <= 1'b0;
      fan_speed_3_sync <= 1'b0;
    end
    else
    begin
      sync1_r <= speed3_pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (!cfg.speed3_sel && (sync2_r == sync3_r))
        fan_speed_3_sync <= sync3_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      drive2_pin_out <= 1'b0;
    else
      drive2_pin_out <= cfg.drive2_sel ? 1'b0 : drive2_level;
  end

  // Open-drain when used as alert: only ever pulls low
  assign speed3_pin_out = 1'b0;
  assign speed3_pin_oe  = cfg.speed3_sel && alert_active;
  assign drive2_pin_oe  = cfg.drive2_sel ? alert_active : 1'b1;

  chk_alert_needs_en: assert property (@(posedge clk) disable iff (sys_rst)
    !cfg.alert_out_en |=> !alert_active)
    else $error("alert asserted while output enable is clear");

  chk_alert_volt_grp: assert property (@(posedge clk) disable iff (sys_rst)
    (cfg.alert_out_en && cfg.volt_grp_en && (|volt_status)) |=> alert_active)
    else $error("enabled voltage status did not raise alert");

endmodule

// [verilog/mcier_regs.sv]
// Configuration and interrupt-enable register bank of the monitor
module mcier_regs
  import mcier_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic [7:0]                reg_addr,
  input  wire logic                      reg_wr_en,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_rd_en,
  output logic      [7:0]                reg_rdata,
  input  wire logic                      regs_locked,
  input  wire logic                      temp_ready_in,
  output logic                           soft_reset_pulse,
  output logic                           low_power_state_sel,
  output logic                           monitor_cycle_sel,
  output logic      [7:0]                remote_avg_count,
  output logic      [7:0]                local_avg_count,
  output logic                           spinup_shorten_en,
  output logic      [7:0]                tach_drive_assoc,
  input  wire logic [NUM_VOLT-1:0]       volt_limit_evt,
  input  wire logic [NUM_TACH-1:0]       tach_limit_evt,
  input  wire logic [NUM_DRIVE-1:0][7:0] drive_duty,
  input  wire logic [NUM_DRIVE-1:0]      fan_disabled,
  input  wire logic [NUM_TACH-1:0][15:0] tach_min_limit,
  output logic      [NUM_VOLT-1:0]       volt_status_set,
  output logic      [NUM_TACH-1:0]       tach_status_set,
  input  wire logic [NUM_VOLT-1:0]       volt_status,
  input  wire logic [NUM_TACH-1:0]       tach_status,
  input  wire logic                      temp_alert_req,
  input  wire logic                      drive2_level,
  input  wire logic                      speed3_pin_in,
  output logic                           speed3_pin_out,
  output logic                           speed3_pin_oe,
  output logic                           fan_speed_3_sync,
  output logic                           drive2_pin_out,
  output logic                           drive2_pin_oe,
  output logic                           alert_active
);

  logic [7:0] special_function_ctrl_r;
  logic [7:0] voltage_irq_enable_r;
  logic [7:0] device_configuration_r;
  logic [7:0] fan_tach_irq_enable_r;
  logic [7:0] tach_drive_association_r;
  logic       init_r;
  logic [7:0] remote_avg_r;
  logic [7:0] local_avg_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] cfg_view;
  logic       wr_ok;
  logic       bank_rst;

  mcier_cfg_if cfg_bus ();

  // A locked bank still answers reads; only writes are dropped
  assign wr_ok    = reg_wr_en && !regs_locked;
  // Soft reset reuses the power-on defaults; reading registers live elsewhere
  assign bank_rst = sys_rst || init_r;

  function automatic logic wr_hit(input logic [7:0] target);
    return wr_ok && (reg_addr == target);
  endfunction

  always_ff @(posedge clk)
  begin
    if (bank_rst)
      special_function_ctrl_r <= RST_SPECIAL_FUNC;
    else if (wr_hit(ADDR_SPECIAL_FUNC))
      special_function_ctrl_r <= reg_wdata;
  end

  always_ff @(posedge clk)
  begin
    if (bank_rst)
      voltage_irq_enable_r <= RST_VOLT_IRQ_EN;
    else if (wr_hit(ADDR_VOLT_IRQ_EN))
      voltage_irq_enable_r <= reg_wdata & VIE_MASK;
  end

  // Bits 5 and 6 are stored as written; the host must keep them at zero
  always_ff @(posedge clk)
  begin
    if (bank_rst)
      device_configuration_r <= RST_DEV_CFG;
    else if (wr_hit(ADDR_DEV_CFG))
      device_configuration_r <= reg_wdata & CFG_MASK;
  end

  always_ff @(posedge clk)
  begin
    if (bank_rst)
      fan_tach_irq_enable_r <= RST_TACH_IRQ_EN;
    else if (wr_hit(ADDR_TACH_IRQ_EN))
      fan_tach_irq_enable_r <= reg_wdata & TIE_MASK;
  end

  always_ff @(posedge clk)
  begin
    if (bank_rst)
      tach_drive_association_r <= RST_TACH_ASSOC;
    else if (wr_hit(ADDR_TACH_ASSOC))
      tach_drive_association_r <= reg_wdata;
  end

  // One-cycle trigger; reset clears it, so it never needs a write of 0
  always_ff @(posedge clk)
  begin
    if (sys_rst || init_r)
      init_r <= 1'b0;
    else if (wr_hit(ADDR_DEV_CFG) && reg_wdata[CFG_INIT_BIT])
      init_r <= 1'b1;
  end

  // Averaging depth handed to the converter sequencer
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      remote_avg_r <= AVG_16;
      local_avg_r  <= AVG_16;
    end
    else
    begin
      remote_avg_r <= mcier_avg_count(special_function_ctrl_r[SF_AVG_MSB:SF_AVG_LSB], 1'b1);
      local_avg_r  <= mcier_avg_count(special_function_ctrl_r[SF_AVG_MSB:SF_AVG_LSB], 1'b0);
    end
  end

  always_comb
  begin
    cfg_view                     = device_configuration_r;
    cfg_view[CFG_TEMP_VALID_BIT] = temp_ready_in;
    cfg_view[CFG_INIT_BIT]       = init_r;
  end

  always_comb
  begin
    case (reg_addr)
      ADDR_SPECIAL_FUNC:
        rdata_nxt = special_function_ctrl_r;
      ADDR_VOLT_IRQ_EN:
        rdata_nxt = voltage_irq_enable_r;
      ADDR_DEV_CFG:
        rdata_nxt = cfg_view;
      ADDR_TACH_IRQ_EN:
        rdata_nxt = fan_tach_irq_enable_r;
      ADDR_TACH_ASSOC:
        rdata_nxt = tach_drive_association_r;
      default:
        rdata_nxt = RDATA_UNMAPPED;
    endcase
  end

  // Read data holds until the next read strobe
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rdata_r <= RDATA_UNMAPPED;
    else if (reg_rd_en)
      rdata_r <= rdata_nxt;
  end

  assign reg_rdata           = rdata_r;
  assign soft_reset_pulse    = init_r;
  assign low_power_state_sel = special_function_ctrl_r[SF_LOW_POWER_BIT];
  assign monitor_cycle_sel   = special_function_ctrl_r[SF_MONITOR_BIT];
  assign remote_avg_count    = remote_avg_r;
  assign local_avg_count     = local_avg_r;
  assign spinup_shorten_en   = device_configuration_r[CFG_SPINUP_BIT];
  assign tach_drive_assoc    = tach_drive_association_r;

  genvar v;
  generate
    for (v = 0; v < NUM_VOLT; v++)
    begin : g_volt_en
      assign cfg_bus.volt_en[v] = voltage_irq_enable_r[VOLT_EN_POS[v]];
    end
  endgenerate

  assign cfg_bus.tach_en      = fan_tach_irq_enable_r[TIE_TACH_LSB +: NUM_TACH];
  assign cfg_bus.assoc        = tach_drive_association_r;
  assign cfg_bus.volt_grp_en  = voltage_irq_enable_r[VIE_GROUP_BIT];
  assign cfg_bus.tach_grp_en  = fan_tach_irq_enable_r[TIE_GROUP_BIT];
  assign cfg_bus.alert_out_en = special_function_ctrl_r[SF_ALERT_EN_BIT];
  assign cfg_bus.speed3_sel   = device_configuration_r[CFG_SPEED3_BIT];
  assign cfg_bus.drive2_sel   = device_configuration_r[CFG_DRIVE2_BIT];

  mcier_event_gate u_event_gate
  (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .cfg             (cfg_bus),
    .volt_limit_evt  (volt_limit_evt),
    .tach_limit_evt  (tach_limit_evt),
    .drive_duty      (drive_duty),
    .fan_disabled    (fan_disabled),
    .tach_min_limit  (tach_min_limit),
    .volt_status_set (volt_status_set),
    .tach_status_set (tach_status_set)
  );

  mcier_alert_out u_alert_out
  (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .cfg              (cfg_bus),
    .volt_status      (volt_status),
    .tach_status      (tach_status),
    .temp_alert_req   (temp_alert_req),
    .drive2_level     (drive2_level),
    .speed3_pin_in    (speed3_pin_in),
    .speed3_pin_out   (speed3_pin_out),
    .speed3_pin_oe    (speed3_pin_oe),
    .fan_speed_3_sync (fan_speed_3_sync),
    .drive2_pin_out   (drive2_pin_out),
    .drive2_pin_oe    (drive2_pin_oe),
    .alert_active     (alert_active)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence init_request;
    wr_ok && (reg_addr == ADDR_DEV_CFG) && reg_wdata[CFG_INIT_BIT] && !init_r;
  endsequence

  sequence bank_at_defaults;
    !init_r && (special_function_ctrl_r == RST_SPECIAL_FUNC) && (voltage_irq_enable_r == RST_VOLT_IRQ_EN)
    && (fan_tach_irq_enable_r == RST_TACH_IRQ_EN) && (tach_drive_association_r == RST_TACH_ASSOC)
    && (device_configuration_r == RST_DEV_CFG);
  endsequence

  chk_soft_reset_seq: assert property (
    init_request |=> init_r ##1 bank_at_defaults)
    else $error("soft reset did not restore register defaults");

  chk_init_self_clear: assert property (
    init_r |=> !init_r)
    else $error("soft reset trigger did not clear itself");

  chk_lock_no_write: assert property (
    (regs_locked && !init_r) |=> ($stable(special_function_ctrl_r) && $stable(voltage_irq_enable_r)
      && $stable(device_configuration_r) && $stable(fan_tach_irq_enable_r) && $stable(tach_drive_association_r)))
    else $error("locked register changed");

  chk_avg_top_prio: assert property (
    special_function_ctrl_r[SF_AVG_MSB] |=> (remote_avg_count == AVG_32) && (local_avg_count == AVG_32))
    else $error("top averaging bit did not select 32");

  chk_avg_table_low: assert property (
    (special_function_ctrl_r[SF_AVG_MSB:SF_AVG_LSB] == 3'h0)
      |=> (remote_avg_count == AVG_128) && (local_avg_count == AVG_8))
    else $error("averaging setting 000 decoded wrongly");

  chk_temp_valid_read: assert property (
    (reg_rd_en && (reg_addr == ADDR_DEV_CFG)) |=> (reg_rdata[CFG_TEMP_VALID_BIT] == $past(temp_ready_in)))
    else $error("temperature ready bit read wrongly");

  chk_vie_write_mask: assert property (
    (wr_hit(ADDR_VOLT_IRQ_EN) && !init_r) |=> (voltage_irq_enable_r == ($past(reg_wdata) & VIE_MASK)))
    else $error("voltage enable reserved bits not read as zero");

  chk_tie_write_mask: assert property (
    (wr_hit(ADDR_TACH_IRQ_EN) && !init_r) |=> (fan_tach_irq_enable_r == ($past(reg_wdata) & TIE_MASK)))
    else $error("tach enable reserved bits not read as zero");

  chk_assoc_write: assert property (
    (wr_hit(ADDR_TACH_ASSOC) && !init_r) |=> (tach_drive_association_r == $past(reg_wdata)))
    else $error("association register write not stored");

  // Checked on the first free edge; an antecedent on reset itself would be disabled
  chk_power_on_defaults: assert property (@(posedge clk)
    $fell(sys_rst) |-> bank_at_defaults)
    else $error("registers not at defaults after reset");

endmodule

// [tb/mcier_host_model.sv]
// Host model that drives the register strobe port
module mcier_host_model
(
  input  wire logic       clk,
  output logic      [7:0] reg_addr  = 8'h00,
  output logic            reg_wr_en = 1'b0,
  output logic      [7:0] reg_wdata = 8'h00,
  output logic            reg_rd_en = 1'b0,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import mcier_pkg::*;

  // Reserved config bits 5 and 6 always go out at their default of 0
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= (a == ADDR_DEV_CFG) ? (d & 8'h9F) : d;
    reg_wr_en <= 1'b1;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    // Released data shows the inverse so a late sample cannot match
    reg_wdata <= ~reg_wdata;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

// [tb/mcier_regs_tb.sv]
// Self-checking bench of the monitor configuration register bank
module mcier_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mcier_pkg::*;

  localparam logic [7:0] RW_ADDR [5] = '{8'h7C, 8'h7E, 8'h7F, 8'h80, 8'h81};
  localparam logic [7:0] RW_EXP  [5] = '{8'hFF, 8'hED, 8'h03, 8'h1F, 8'hFF};

  logic clk = 1'b0;
  logic sys_rst, regs_locked, temp_ready_in, temp_alert_req, drive2_level, speed3_pin_in;
  logic reg_wr_en, reg_rd_en, soft_reset_pulse, low_power_state_sel, monitor_cycle_sel;
  logic spinup_shorten_en, speed3_pin_out, speed3_pin_oe, fan_speed_3_sync;
  logic drive2_pin_out, drive2_pin_oe, alert_active;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, remote_avg_count, local_avg_count, tach_drive_assoc;
  logic [NUM_VOLT-1:0] volt_limit_evt, volt_status, volt_status_set;
  logic [NUM_TACH-1:0] tach_limit_evt, tach_status, tach_status_set;
  logic [NUM_DRIVE-1:0][7:0] drive_duty;
  logic [NUM_DRIVE-1:0] fan_disabled;
  logic [NUM_TACH-1:0][15:0] tach_min_limit;
  int errors = 0;
  int cmp_count = 0;

  mcier_host_model u_host (.clk, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata);

  mcier_regs u_dut (.clk, .sys_rst, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata,
    .regs_locked, .temp_ready_in, .soft_reset_pulse, .low_power_state_sel, .monitor_cycle_sel,
    .remote_avg_count, .local_avg_count, .spinup_shorten_en, .tach_drive_assoc, .volt_limit_evt,
    .tach_limit_evt, .drive_duty, .fan_disabled, .tach_min_limit, .volt_status_set, .tach_status_set,
    .volt_status, .tach_status, .temp_alert_req, .drive2_level, .speed3_pin_in, .speed3_pin_out,
    .speed3_pin_oe, .fan_speed_3_sync, .drive2_pin_out, .drive2_pin_oe, .alert_active);

  always #4 clk = ~clk;

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    chk("reg_rdata", exp, d);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic evt_chk(input logic [7:0] ev, input logic [7:0] et);
    settle(2);
    chk("volt_status_set", ev, volt_status_set);
    chk("tach_status_set", et, tach_status_set);
  endtask

  task automatic chk_defaults();
    rd_chk(ADDR_SPECIAL_FUNC, 8'h40);
    rd_chk(ADDR_VOLT_IRQ_EN, 8'hEC);
    rd_chk(ADDR_DEV_CFG, 8'h10);
    rd_chk(ADDR_TACH_IRQ_EN, 8'h1E);
    rd_chk(ADDR_TACH_ASSOC, 8'hA4);
  endtask

  // Whole run needs well under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict();
  end

  initial
  begin
    logic ea;
    {sys_rst, regs_locked, temp_ready_in, temp_alert_req, drive2_level, speed3_pin_in} = 6'b100000;
    {volt_limit_evt, volt_status, tach_limit_evt, tach_status} = '0;
    {drive_duty, fan_disabled, tach_min_limit} = '0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    chk_defaults();
    chk("remote_avg_count", 8'h10, remote_avg_count);
    chk("local_avg_count", 8'h10, local_avg_count);
    chk("low_power_state_sel", 8'h00, low_power_state_sel);
    chk("monitor_cycle_sel", 8'h00, monitor_cycle_sel);
    chk("spinup_shorten_en", 8'h01, spinup_shorten_en);
    for (int i = 0; i < 5; i++)
      u_host.wr(RW_ADDR[i], (i == 2) ? 8'h67 : 8'hFF);
    for (int i = 0; i < 5; i++)
      rd_chk(RW_ADDR[i], RW_EXP[i]);
    chk("spinup_shorten_en", 8'h00, spinup_shorten_en);
    u_host.wr(8'h7D, 8'h5A);
    rd_chk(8'h7D, 8'h00);
    @(posedge clk) regs_locked <= 1'b1;
    u_host.wr(ADDR_SPECIAL_FUNC, 8'h00);
    u_host.wr(ADDR_TACH_ASSOC, 8'h00);
    rd_chk(ADDR_SPECIAL_FUNC, 8'hFF);
    rd_chk(ADDR_TACH_ASSOC, 8'hFF);
    @(posedge clk) regs_locked <= 1'b0;
    @(posedge clk) temp_ready_in <= 1'b1;
    rd_chk(ADDR_DEV_CFG, 8'h0B);
    for (int s = 0; s < 8; s++)
    begin
      u_host.wr(ADDR_SPECIAL_FUNC, {s[2:0], 5'h00});
      settle(2);
      chk("remote_avg_count", s[2] ? 8'h20 : s[1] ? 8'h10 : s[0] ? 8'h10 : 8'h80, remote_avg_count);
      chk("local_avg_count", s[2] ? 8'h20 : s[1] ? 8'h10 : s[0] ? 8'h01 : 8'h08, local_avg_count);
    end
    u_host.wr(ADDR_SPECIAL_FUNC, 8'h03);
    settle(2);
    chk("low_power_state_sel", 8'h01, low_power_state_sel);
    chk("monitor_cycle_sel", 8'h01, monitor_cycle_sel);
    // Every tach is tied to a drive, so no drive is left without one
    u_host.wr(ADDR_TACH_ASSOC, 8'hA4);
    u_host.wr(ADDR_VOLT_IRQ_EN, 8'hEC);
    u_host.wr(ADDR_TACH_IRQ_EN, 8'h1E);
    @(posedge clk);
    drive_duty <= {3{8'h80}};
    tach_min_limit <= {4{16'h1000}};
    volt_limit_evt <= 5'h1F;
    tach_limit_evt <= 4'hF;
    evt_chk(8'h1F, 8'h0F);
    chk("tach_drive_assoc", 8'hA4, tach_drive_assoc);
    u_host.wr(ADDR_VOLT_IRQ_EN, 8'h24);
    u_host.wr(ADDR_TACH_IRQ_EN, 8'h0A);
    evt_chk(8'h05, 8'h05);
    u_host.wr(ADDR_TACH_IRQ_EN, 8'h1E);
    @(posedge clk) drive_duty[2] <= 8'h00;
    evt_chk(8'h05, 8'h03);
    @(posedge clk) fan_disabled[0] <= 1'b1;
    evt_chk(8'h05, 8'h02);
    @(posedge clk) tach_min_limit[1] <= 16'hFFFF;
    evt_chk(8'h05, 8'h00);
    for (int i = 0; i < 32; i++)
    begin
      u_host.wr(ADDR_SPECIAL_FUNC, i[0] ? 8'h04 : 8'h00);
      u_host.wr(ADDR_VOLT_IRQ_EN, {7'h00, i[1]});
      u_host.wr(ADDR_TACH_IRQ_EN, {7'h00, i[2]});
      @(posedge clk);
      volt_status <= {4'h0, i[3]};
      tach_status <= {3'h0, ~i[3]};
      temp_alert_req <= i[4];
      drive2_level <= 1'b1;
      settle(2);
      ea = i[0] & ((i[1] & i[3]) | (i[2] & ~i[3]) | i[4]);
      chk("alert_active", ea, alert_active);
      chk("speed3_pin_oe", ea, speed3_pin_oe);
      chk("drive2_pin_oe", ea, drive2_pin_oe);
      chk("speed3_pin_out", 8'h00, speed3_pin_out);
      chk("drive2_pin_out", 8'h00, drive2_pin_out);
    end
    u_host.wr(ADDR_DEV_CFG, 8'h10);
    for (int k = 1; k >= 0; k--)
    begin
      @(posedge clk);
      speed3_pin_in <= k[0];
      drive2_level <= k[0];
      settle(6);
      chk("fan_speed_3_sync", k[0], fan_speed_3_sync);
      chk("drive2_pin_out", k[0], drive2_pin_out);
      chk("drive2_pin_oe", 8'h01, drive2_pin_oe);
      chk("speed3_pin_oe", 8'h00, speed3_pin_oe);
    end
    @(posedge clk) temp_ready_in <= 1'b0;
    u_host.wr(ADDR_DEV_CFG, 8'h80);
    #1;
    chk("soft_reset_pulse", 8'h01, soft_reset_pulse);
    settle(1);
    chk("soft_reset_pulse", 8'h00, soft_reset_pulse);
    chk_defaults();
    print_verdict();
  end
endmodule
